/* File: cqs_regs.svh */
// Purpose: Named constants of the class-of-service queue scheduler.
// Assumes: Queue codes 2'h0..2'h3 stand for forwarding queues 1..4.
// Notes: Definitions only.
`ifndef CQS_REGS_SVH
`define CQS_REGS_SVH
`define CQS_Q_LOW       2'h0
`define CQS_Q_TOP       2'h3
`define CQS_PROT_COS    3'h5
`define CQS_COS_RST     3'h0
`define CQS_DEF_MAP     16'hfa50
`define CQS_WT_Q1       4'h1
`define CQS_WT_Q2       4'h2
`define CQS_WT_Q3       4'ha
`define CQS_FIFO_DEPTH  8
`endif

/* File: cqs_pkg.sv */
// Purpose: Types shared by the class-of-service queue scheduler.
// Assumes: Packet payload is one word per packet descriptor.
// Notes: Map entry k sits in bits [2k+1:2k].
package cqs_pkg;
  localparam int CQS_DATA_W = 32;
  typedef logic [7:0][1:0] cqs_map_t;
  typedef struct packed {
    logic                  tagged_v;
    logic [2:0]            pcp;
    logic [CQS_DATA_W-1:0] data;
  } cqs_pkt_s;
  typedef struct packed {
    logic [2:0] cos;
    logic [1:0] queue;
  } cqs_map_wr_s;
  typedef struct packed {
    logic [1:0]            queue;
    logic [CQS_DATA_W-1:0] data;
  } cqs_out_s;
  typedef enum logic [1:0] {
    CQS_RR_Q1 = 2'b00,
    CQS_RR_Q2 = 2'b01,
    CQS_RR_Q3 = 2'b11
  } cqs_rr_e;
endpackage

/* File: cqs_sched.sv */
// What this block does
// - Class of service is 0..7, 7 highest.
// - Four queues, 1 lowest, 4 highest.
// - Queue 4 always served first when occupied.
// - Queues 1-3 share by weights 1,2,10.
// - Classes 0-5 never mapped to queue 4.
// - Packets enqueue where the table maps class.
// - Restore reloads factory default table.
// - Staged entry takes effect after commit.
// - Untagged packets use default class, reset 0.
// - Global enable off disables class queueing.
// Purpose: Map packets to four egress queues and schedule them out.
// Assumes: One clock, clk_sys at 25 MHz; all inputs synchronous.
// Notes: Queue codes 0..3 stand for queues 1..4.
`timescale 1ns/1ps
`default_nettype none
`include "cqs_regs.svh"

module cqs_fifo #(
  parameter int W = 32,
  parameter int D = `CQS_FIFO_DEPTH
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic         wr_valid,
  input  wire logic [W-1:0] wr_data,
  output logic              wr_ready,
  output logic              rd_valid,
  output logic [W-1:0]      rd_data,
  input  wire logic         rd_ready
);
  localparam int AW = $clog2(D);
  if (D < 2 || (1 << AW) != D) begin : g_bad_depth
    $error("cqs_fifo depth must be a power of two, at least 2");
  end
  logic [W-1:0]  mem_reg [D];
  logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [AW:0]   cnt_reg, cnt_next;
  logic          wr, rd;

  assign wr_ready = (cnt_reg != (AW+1)'(D));
  assign rd_valid = (cnt_reg != '0);
  assign rd_data  = mem_reg[rp_reg];

  always_comb begin
    wr       = ce & wr_valid & wr_ready;
    rd       = ce & rd_valid & rd_ready;
    wp_next  = wr ? wp_reg + 1'b1 : wp_reg;
    rp_next  = rd ? rp_reg + 1'b1 : rp_reg;
    cnt_next = cnt_reg + (AW+1)'(wr) - (AW+1)'(rd);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      wp_reg  <= wp_next;
      rp_reg  <= rp_next;
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (wr) begin
      mem_reg[wp_reg] <= wr_data;
    end
  end
endmodule // cqs_fifo

module cqs_sched #(
  parameter int DEPTH = `CQS_FIFO_DEPTH
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  input  wire logic                 ce,
  input  wire logic                 in_valid,
  input  wire cqs_pkg::cqs_pkt_s    in_pkt,
  output var logic                  in_ready,
  input  wire logic                 qos_en,
  input  wire logic                 dflt_cos_wr,
  input  wire logic [2:0]           dflt_cos,
  input  wire logic                 map_wr,
  input  wire cqs_pkg::cqs_map_wr_s map_cfg,
  input  wire logic                 map_commit,
  input  wire logic                 map_restore,
  output var logic                  map_rej,
  output var logic                  out_valid,
  output var cqs_pkg::cqs_out_s     out_pkt,
  input  wire logic                 out_ready
);
  import cqs_pkg::*;
  if (DEPTH < 2) begin : g_bad_param
    $error("cqs_sched needs DEPTH of at least 2");
  end

  cqs_map_t  act_reg, act_next, shd_reg, shd_next;
  logic [2:0] dcos_reg, dcos_next;
  logic       rej_reg, rej_next;
  logic       bad_wr;

  // Table upkeep: restore beats commit and a staged write; commit takes a same-cycle write.
  always_comb begin
    act_next  = act_reg;
    shd_next  = shd_reg;
    dcos_next = dcos_reg;
    rej_next  = 1'b0;
    bad_wr    = (map_cfg.cos <= `CQS_PROT_COS) && (map_cfg.queue == `CQS_Q_TOP);
    if (ce) begin
      if (dflt_cos_wr) begin
        dcos_next = dflt_cos;
      end
      if (map_wr) begin
        rej_next = bad_wr;
        if (!bad_wr) begin
          shd_next[map_cfg.cos] = map_cfg.queue;
        end
      end
      if (map_restore) begin
        act_next = `CQS_DEF_MAP;
        shd_next = `CQS_DEF_MAP;
      end else if (map_commit) begin
        act_next = shd_next;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      act_reg  <= `CQS_DEF_MAP;
      shd_reg  <= `CQS_DEF_MAP;
      dcos_reg <= `CQS_COS_RST;
      rej_reg  <= 1'b0;
    end else begin
      act_reg  <= act_next;
      shd_reg  <= shd_next;
      dcos_reg <= dcos_next;
      rej_reg  <= rej_next;
    end
  end
  assign map_rej = rej_reg;

  // Classify into a one-entry stage, then push into the chosen queue.
  cqs_out_s   stg_reg, stg_next;
  logic       stg_vld_reg, stg_vld_next, rdy_reg, rdy_next, accept, drain;
  logic [2:0] cls;
  logic [3:0] f_wr_rdy, q_vld, pop;
  logic [CQS_DATA_W-1:0] q_data [4];

  always_comb begin
    cls          = in_pkt.tagged_v ? in_pkt.pcp : dcos_reg;
    accept       = ce & in_valid & rdy_reg;
    drain        = ce & stg_vld_reg & f_wr_rdy[stg_reg.queue];
    stg_next     = stg_reg;
    stg_vld_next = stg_vld_reg;
    if (accept) begin
      stg_next.queue = qos_en ? act_reg[cls] : `CQS_Q_LOW;
      stg_next.data  = in_pkt.data;
      stg_vld_next   = 1'b1;
    end else if (drain) begin
      stg_vld_next = 1'b0;
    end
    rdy_next = ~stg_vld_next;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stg_reg     <= '0;
      stg_vld_reg <= 1'b0;
      rdy_reg     <= 1'b0;
    end else begin
      stg_reg     <= stg_next;
      stg_vld_reg <= stg_vld_next;
      rdy_reg     <= rdy_next;
    end
  end
  assign in_ready = rdy_reg;

  for (genvar q = 0; q < 4; q++) begin : g_queue
    cqs_fifo #(.W(CQS_DATA_W), .D(DEPTH)) u_fifo (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .ce       (ce),
      .wr_valid (stg_vld_reg && (stg_reg.queue == 2'(q))),
      .wr_data  (stg_reg.data),
      .wr_ready (f_wr_rdy[q]),
      .rd_valid (q_vld[q]),
      .rd_data  (q_data[q]),
      .rd_ready (pop[q])
    );
  end

  function automatic logic [1:0] rr_idx(cqs_rr_e r);
    unique case (r)
      CQS_RR_Q1: rr_idx = 2'h0;
      CQS_RR_Q2: rr_idx = 2'h1;
      CQS_RR_Q3: rr_idx = 2'h2;
      default:   rr_idx = 2'h0;
    endcase
  endfunction
  function automatic cqs_rr_e rr_of(logic [1:0] i);
    rr_of = (i == 2'h0) ? CQS_RR_Q1 : (i == 2'h1) ? CQS_RR_Q2 : CQS_RR_Q3;
  endfunction
  function automatic logic [3:0] wt_of(logic [1:0] i);
    wt_of = (i == 2'h0) ? `CQS_WT_Q1 : (i == 2'h1) ? `CQS_WT_Q2 : `CQS_WT_Q3;
  endfunction

  // Scheduler: strict top queue, packet-counted round robin below it.
  cqs_rr_e    rr_reg, rr_next;
  logic [3:0] wcnt_reg, wcnt_next, served;
  logic [1:0] cur, cand, pick_q;
  logic       pick_vld, load, out_vld_reg, out_vld_next;
  cqs_out_s   out_reg, out_next;

  always_comb begin
    cur       = rr_idx(rr_reg);
    load      = ce & (~out_vld_reg | out_ready);
    pick_vld  = 1'b0;
    pick_q    = `CQS_Q_TOP;
    cand      = cur;
    served    = '0;
    rr_next   = rr_reg;
    wcnt_next = wcnt_reg;
    if (q_vld[3]) begin
      pick_vld = 1'b1;
    end else begin
      for (int k = 2; k >= 0; k--) begin
        if (q_vld[2'((int'(cur) + k) % 3)]) begin
          cand = 2'((int'(cur) + k) % 3);
        end
      end
      pick_vld = q_vld[cand];
      pick_q   = cand;
      if (load && pick_vld) begin
        served = ((cand == cur) ? wcnt_reg : 4'h0) + 4'h1;
        if (served >= wt_of(cand)) begin
          rr_next   = rr_of((cand == 2'h2) ? 2'h0 : cand + 2'h1);
          wcnt_next = '0;
        end else begin
          rr_next   = rr_of(cand);
          wcnt_next = served;
        end
      end
    end
    for (int q = 0; q < 4; q++) begin
      pop[q] = load & pick_vld & (pick_q == 2'(q));
    end
    out_vld_next = load ? pick_vld : out_vld_reg;
    out_next     = out_reg;
    if (load && pick_vld) begin
      out_next.queue = pick_q;
      out_next.data  = q_data[pick_q];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rr_reg      <= CQS_RR_Q1;
      wcnt_reg    <= '0;
      out_vld_reg <= 1'b0;
      out_reg     <= '0;
    end else begin
      rr_reg      <= rr_next;
      wcnt_reg    <= wcnt_next;
      out_vld_reg <= out_vld_next;
      out_reg     <= out_next;
    end
  end
  assign out_valid = out_vld_reg;
  assign out_pkt   = out_reg;

  logic low_top;
  always_comb begin
    low_top = 1'b0;
    for (int c = 0; c <= 5; c++) begin
      low_top = low_top | (act_reg[c] == `CQS_Q_TOP);
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_low_serve;
    load && !q_vld[3] && pick_vld;
  endsequence
  sequence s_top_serve;
    load && q_vld[3];
  endsequence

  chk_top_first: assert property (s_top_serve |=> out_valid && out_pkt.queue == 2'h3)
    else $error("Top queue not served first.");
  chk_low_share: assert property (s_low_serve |=> out_valid && out_pkt.queue != 2'h3)
    else $error("Lower queue pick went wrong.");
  chk_wrr_credit: assert property (wcnt_reg < wt_of(rr_idx(rr_reg)))
    else $error("Round robin credit exceeds weight.");
  chk_reserved_rej: assert property (ce && map_wr && bad_wr && !map_restore |=> map_rej && shd_reg == $past(shd_reg))
    else $error("Reserved mapping not refused.");
  chk_reserved_kept: assert property (!low_top)
    else $error("Low class mapped to top queue.");
  chk_restore_load: assert property (ce && map_restore |=> act_reg == `CQS_DEF_MAP)
    else $error("Restore did not reload defaults.");
  chk_commit_apply: assert property (ce && map_commit && !map_restore && !map_wr |=> act_reg == $past(shd_reg))
    else $error("Commit did not apply staged table.");
  chk_enqueue_map: assert property (accept && qos_en |=> stg_reg.queue == $past(act_reg[cls]))
    else $error("Packet queued off the table.");
  chk_qos_off: assert property (accept && !qos_en |=> stg_reg.queue == 2'h0)
    else $error("Disabled QoS still classified.");
  chk_untag_dflt: assert property (accept && qos_en && !in_pkt.tagged_v |=> stg_reg.queue == $past(act_reg[dcos_reg]))
    else $error("Untagged packet ignored default class.");
endmodule // cqs_sched
`default_nettype wire

/* File: cqs_sink.sv */
// Purpose: Port transmit model that takes packets from the scheduler.
// Assumes: One clock; ready changes only just after a rising edge.
// Notes: Each taken packet is kept in got, in order, for the bench.
`timescale 1ns/1ps
`default_nettype none
module cqs_sink (
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic              stall,
  input  wire logic              out_valid,
  input  wire cqs_pkg::cqs_out_s out_pkt,
  output logic                   out_ready
);
  import cqs_pkg::*;
  cqs_out_s got[$];
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      out_ready <= 1'b0;
    end else begin
      if (out_valid && out_ready) begin
        got.push_back(out_pkt);
      end
      out_ready <= !stall;
    end
  end
endmodule // cqs_sink
`default_nettype wire

/* File: tb.sv */
// Purpose: Self-checking bench of the class-of-service queue scheduler.
// Assumes: Inputs change on the falling edge of clk_sys.
// Notes: Queue codes 0..3 stand for queues 1..4.
`timescale 1ns/1ps
`default_nettype none
`include "cqs_regs.svh"
module tb;
  import cqs_pkg::*;
  logic        clk_sys     = 1'b0;
  logic        rst_n       = 1'b0;
  logic        ce          = 1'b1;
  logic        in_valid    = 1'b0;
  cqs_pkt_s    in_pkt      = '0;
  logic        qos_en      = 1'b1;
  logic        dflt_cos_wr = 1'b0;
  logic [2:0]  dflt_cos    = 3'h0;
  logic        map_wr      = 1'b0;
  cqs_map_wr_s map_cfg     = '0;
  logic        map_commit  = 1'b0;
  logic        map_restore = 1'b0;
  logic        stall       = 1'b0;
  logic        in_ready;
  logic        map_rej;
  logic        out_valid;
  logic        out_ready;
  cqs_out_s    out_pkt;
  logic [31:0] pkt_id      = 32'h0;
  int          fail_count  = 0;
  int          comparisons = 0;
  int          cycles      = 0;
  cqs_sched dut (.clk_sys, .rst_n, .ce, .in_valid, .in_pkt, .in_ready, .qos_en,
    .dflt_cos_wr, .dflt_cos, .map_wr, .map_cfg, .map_commit, .map_restore,
    .map_rej, .out_valid, .out_pkt, .out_ready);
  cqs_sink sink (.clk_sys, .rst_n, .stall, .out_valid, .out_pkt, .out_ready);
  always #20 clk_sys = ~clk_sys;
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      test_done();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic send(input logic tg, input logic [2:0] p);
    @(negedge clk_sys);
    in_valid = 1'b1;
    in_pkt = '{tg, p, pkt_id};
    pkt_id++;
    while (in_ready !== 1'b1) @(negedge clk_sys);
    @(negedge clk_sys);
    in_valid = 1'b0;
  endtask
  task automatic probe(input logic tg, input logic [2:0] p, input logic [1:0] q);
    int k;
    k = sink.got.size();
    send(tg, p);
    while (sink.got.size() == k) @(negedge clk_sys);
    chk(32'(sink.got[k].queue), 32'(q));
    chk(sink.got[k].data, pkt_id - 32'h1);
  endtask
  task automatic cfg(input logic w, input logic [2:0] c, input logic [1:0] q,
                     input logic cm, input logic rs, input logic rej);
    @(negedge clk_sys);
    map_wr = w;
    map_cfg = '{c, q};
    map_commit = cm;
    map_restore = rs;
    @(negedge clk_sys);
    {map_wr, map_commit, map_restore} = 3'h0;
    chk(32'(map_rej), 32'(rej));
  endtask
  task automatic t_reset_map();
    for (int p = 0; p < 8; p++) begin
      probe(1'b1, 3'(p), 2'(`CQS_DEF_MAP >> (2 * p)));
    end
  endtask
  task automatic t_map();
    cfg(1'b1, 3'h2, 2'h2, 1'b0, 1'b0, 1'b0);
    probe(1'b1, 3'h2, 2'h1);
    cfg(1'b0, 3'h0, 2'h0, 1'b1, 1'b0, 1'b0);
    probe(1'b1, 3'h2, 2'h2);
    cfg(1'b1, 3'h5, 2'h3, 1'b1, 1'b0, 1'b1);
    probe(1'b1, 3'h5, 2'h2);
    cfg(1'b1, 3'h6, 2'h0, 1'b1, 1'b0, 1'b0);
    probe(1'b1, 3'h6, 2'h0);
    cfg(1'b0, 3'h0, 2'h0, 1'b0, 1'b1, 1'b0);
    probe(1'b1, 3'h2, 2'h1);
    probe(1'b1, 3'h6, 2'h3);
  endtask
  task automatic t_untag();
    probe(1'b0, 3'h7, 2'h0);
    @(negedge clk_sys);
    dflt_cos_wr = 1'b1;
    dflt_cos = 3'h7;
    @(negedge clk_sys);
    dflt_cos_wr = 1'b0;
    probe(1'b0, 3'h0, 2'h3);
    probe(1'b1, 3'h0, 2'h0);
  endtask
  task automatic t_qos();
    @(negedge clk_sys);
    qos_en = 1'b0;
    probe(1'b1, 3'h7, 2'h0);
    @(negedge clk_sys);
    qos_en = 1'b1;
  endtask
  task automatic t_sched();
    logic [2:0] pl [15] = '{0, 2, 2, 2, 4, 4, 4, 4, 4, 4, 4, 4, 0, 0, 6};
    logic [1:0] ex [15] = '{0, 3, 1, 1, 2, 2, 2, 2, 2, 2, 2, 2, 0, 1, 0};
    int k;
    k = sink.got.size();
    stall = 1'b1;
    foreach (pl[i]) send(1'b1, pl[i]);
    stall = 1'b0;
    while (sink.got.size() < k + 15) @(negedge clk_sys);
    foreach (ex[i]) chk(32'(sink.got[k + i].queue), 32'(ex[i]));
  endtask
  initial begin
    repeat (12) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk(32'(in_ready), 32'h1);
    t_reset_map();
    t_map();
    t_untag();
    t_qos();
    t_sched();
    test_done();
  end
endmodule // tb
`default_nettype wire
